// >>> rtl/fbp_pkg.sv
// package for the five-bit port with chip selects: register map, reset values, field positions
// assumes a Wishbone byte address of FBP_ADR_W bits and one 8-bit register per 32-bit word
package fbp_pkg;

  // bus geometry
  localparam int unsigned FBP_ADR_W  = 18;
  localparam int unsigned FBP_IDX_W  = 16;
  localparam int unsigned FBP_PINS   = 5;
  localparam int unsigned FBP_CS_NUM = 4;

  // register indices; byte address is four times the index
  localparam logic [15:0] FBP_IDX_DIR      = 16'hFE3F;
  localparam logic [15:0] FBP_IDX_DATA     = 16'hFF0F;
  localparam logic [15:0] FBP_IDX_PIN      = 16'hFFBF;
  localparam logic [15:0] FBP_IDX_CTRL     = 16'hFE50;
  localparam logic [15:0] FBP_IDX_IRQ_STAT = 16'hFE51;
  localparam logic [15:0] FBP_IDX_IRQ_MASK = 16'hFE52;

  // values after power-on reset or hardware standby
  localparam logic [4:0] FBP_DIR_RST_CS   = 5'h10;
  localparam logic [4:0] FBP_DIR_RST_PLAIN = 5'h00;
  localparam logic [4:0] FBP_DATA_RST     = 5'h00;
  localparam logic [0:0] FBP_CTRL_RST     = 1'h0;
  localparam logic [1:0] FBP_IRQ_RST      = 2'h0;
  localparam logic [7:0] FBP_UNDEF_READ   = 8'h00;

  // field positions
  localparam int unsigned FBP_CTRL_HOLD_BIT = 0;
  localparam int unsigned FBP_PIN_EXT_INTERRUPT_6_N      = 0;
  localparam int unsigned FBP_PIN_EXT_INTERRUPT_7_N      = 1;
  localparam int unsigned FBP_STAT_EXT_INTERRUPT_6_N     = 0;
  localparam int unsigned FBP_STAT_EXT_INTERRUPT_7_N     = 1;

  // operating mode as strapped: modes 4, 5, 6, 7
  typedef enum logic [1:0] {
    FBP_MODE4,
    FBP_MODE5,
    FBP_MODE6,
    FBP_MODE7
  } fbp_mode_t;

  // drive of the pads: level and active-low enable
  typedef struct packed {
    logic [4:0] level;
    logic [4:0] oe_n;
  } fbp_drive_t;

endpackage

// >>> rtl/fbp_port.sv
// five-bit general-purpose port with chip-select and external-interrupt pin sharing
// assumes a classic Wishbone master on clk_i, chip selects from a bus controller on clk_i,
// and pads resolved outside from pin_o / pin_oe_n_o
//
// Functional notes
// - direction register write-only, reads give filler
// - direction bits 7..5 reserved, no state
// - reset: pin4 direction one in modes 4,5
// - direction kept through manual reset, standby
// - standby holds or floats chip-select outputs
// - modes 4-6: pins 4..1 drive chip selects
// - modes 4-6: pin 0 plain output/input
// - mode 7: all pins plain, no chip selects
// - five data bits, cleared at reset, kept
// - upper three data/pin bits ignored, filler
// - pin-state register read-only, writes ignored
// - pin read: data if output, pin if input
// - pin state follows pins, frozen in standby
// - pins 1,0 feed external interrupts 7,6
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module fbp_port (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [17:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  mode_i,
  input  wire logic        hw_standby_i,
  input  wire logic        sw_standby_i,
  input  wire logic [3:0]  chip_select_n_i,
  input  wire logic [4:0]  pin_i,
  output logic      [4:0]  pin_o,
  output logic      [4:0]  pin_oe_n_o,
  output logic             ext_interrupt_6_n_o,
  output logic             ext_interrupt_7_n_o,
  output logic             irq_o
);

  // modes 4 to 6 share the external-bus pin functions
  function automatic logic bus_mode(input fbp_pkg::fbp_mode_t m);
    bus_mode = (m != fbp_pkg::FBP_MODE7);
  endfunction

  // synchronisers for pads and straps
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic [1:0] mode_s1_reg;
  logic [1:0] mode_s2_reg;
  logic       hws_s1_reg;
  logic       hws_s2_reg;

  always_ff @(posedge clk_i) begin
    pin_s1_reg  <= pin_i;
    pin_s2_reg  <= pin_s1_reg;
    mode_s1_reg <= mode_i;
    mode_s2_reg <= mode_s1_reg;
    hws_s1_reg  <= hw_standby_i;
    hws_s2_reg  <= hws_s1_reg;
  end

  // state
  fbp_pkg::fbp_mode_t mode_reg;
  logic [4:0]         dir_reg;
  logic [4:0]         data_reg;
  logic [4:0]         pin_state_reg;
  logic [4:0]         pin_prev_reg;
  logic [0:0]         ctrl_reg;
  logic [1:0]         stat_reg;
  logic [1:0]         mask_reg;
  logic               ack_reg;
  logic [31:0]        dat_reg;
  logic               irq_reg;
  logic               int6_reg;
  logic               int7_reg;
  fbp_pkg::fbp_drive_t drive_reg;

  // decode
  wire        init_w    = rst_i | hws_s2_reg;
  wire [15:0] idx_w     = wb_adr_i[17:2];
  wire        req_w     = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        wr_w      = req_w & wb_we_i & wb_sel_i[0];
  wire        rd_w      = req_w & ~wb_we_i;
  wire        hit_dir   = (idx_w == fbp_pkg::FBP_IDX_DIR);
  wire        hit_data  = (idx_w == fbp_pkg::FBP_IDX_DATA);
  wire        hit_pin   = (idx_w == fbp_pkg::FBP_IDX_PIN);
  wire        hit_ctrl  = (idx_w == fbp_pkg::FBP_IDX_CTRL);
  wire        hit_stat  = (idx_w == fbp_pkg::FBP_IDX_IRQ_STAT);
  wire        hit_mask  = (idx_w == fbp_pkg::FBP_IDX_IRQ_MASK);
  wire        hold_w    = ctrl_reg[fbp_pkg::FBP_CTRL_HOLD_BIT];
  wire        bus_w     = bus_mode(mode_reg);
  wire        mode7_w   = (mode_reg == fbp_pkg::FBP_MODE7);

  // direction value after reset taken from the strap seen at that moment
  wire        strap_cs_w = (mode_s2_reg == 2'h0) | (mode_s2_reg == 2'h1);
  wire [4:0]  dir_init_w = strap_cs_w ? fbp_pkg::FBP_DIR_RST_CS : fbp_pkg::FBP_DIR_RST_PLAIN;

  // mode latched while reset or hardware standby is held, stays fixed until the next reset or hardware standby
  always_ff @(posedge clk_i) begin
    if (init_w) begin
      mode_reg <= fbp_pkg::fbp_mode_t'(mode_s2_reg);
    end
  end

  // direction: only five bits exist, manual reset and software standby never touch it
  always_ff @(posedge clk_i) begin
    if (init_w) begin
      dir_reg <= dir_init_w;
    end else if (wr_w && hit_dir) begin
      dir_reg <= wb_dat_i[4:0];
    end
  end

  // output data
  always_ff @(posedge clk_i) begin
    if (init_w) begin
      data_reg <= fbp_pkg::FBP_DATA_RST;
    end else if (wr_w && hit_data) begin
      data_reg <= wb_dat_i[4:0];
    end
  end

  // standby output-hold control
  always_ff @(posedge clk_i) begin
    if (init_w) begin
      ctrl_reg <= fbp_pkg::FBP_CTRL_RST;
    end else if (wr_w && hit_ctrl) begin
      ctrl_reg <= wb_dat_i[0:0];
    end
  end

  // pin view: data for outputs, pad level for inputs
  wire [4:0] pin_view_w = (dir_reg & data_reg) | (~dir_reg & pin_s2_reg);

  // snapshot frozen in software standby so reads keep the old contents
  always_ff @(posedge clk_i) begin
    if (init_w) begin
      pin_state_reg <= pin_s2_reg;
    end else if (!sw_standby_i) begin
      pin_state_reg <= pin_view_w;
    end
  end

  wire [4:0] pin_read_w = sw_standby_i ? pin_state_reg : pin_view_w;

  // interrupt events: falling edges on the two shared interrupt pins
  always_ff @(posedge clk_i) begin
    if (init_w) begin
      // start from the pad level: a pin held low through reset must not look like a fresh edge
      pin_prev_reg <= pin_s2_reg;
    end else begin
      pin_prev_reg <= pin_s2_reg;
    end
  end

  wire [1:0] fall_w;
  assign fall_w[fbp_pkg::FBP_STAT_EXT_INTERRUPT_6_N] = pin_prev_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_6_N] & ~pin_s2_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_6_N];
  assign fall_w[fbp_pkg::FBP_STAT_EXT_INTERRUPT_7_N] = pin_prev_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_7_N] & ~pin_s2_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_7_N];

  // read clears, a coincident event survives the clear
  wire [1:0] stat_clr_w  = (rd_w && hit_stat) ? 2'h3 : 2'h0;
  wire [1:0] stat_next   = (stat_reg & ~stat_clr_w) | fall_w;
  wire [1:0] mask_next   = (wr_w && hit_mask) ? wb_dat_i[1:0] : mask_reg;
  wire       irq_next    = |(stat_next & mask_next);

  always_ff @(posedge clk_i) begin
    if (init_w) begin
      stat_reg <= fbp_pkg::FBP_IRQ_RST;
      mask_reg <= fbp_pkg::FBP_IRQ_RST;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end

  // interrupt lines see the pad whatever the port function
  always_ff @(posedge clk_i) begin
    if (init_w) begin
      int6_reg <= 1'b1;
      int7_reg <= 1'b1;
    end else begin
      int6_reg <= pin_s2_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_6_N];
      int7_reg <= pin_s2_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_7_N];
    end
  end

  // read multiplexer; reserved and unreadable bits give the filler byte
  wire [7:0] rd_byte_w =
    hit_dir  ? fbp_pkg::FBP_UNDEF_READ :
    hit_data ? {fbp_pkg::FBP_UNDEF_READ[7:5], data_reg} :
    hit_pin  ? {fbp_pkg::FBP_UNDEF_READ[7:5], pin_read_w} :
    hit_ctrl ? {7'h00, ctrl_reg} :
    hit_stat ? {6'h00, stat_reg} :
    hit_mask ? {6'h00, mask_reg} :
               8'h00;

  // one wait state; unmapped words answer with zero and drop writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req_w;
      dat_reg <= rd_w ? {24'h00_0000, rd_byte_w} : 32'h0000_0000;
    end
  end

  // pad drive per pin
  logic [4:0] cs_func_w;
  logic [4:0] cs_lvl_w;
  fbp_pkg::fbp_drive_t drive_next;

  assign cs_func_w[0] = 1'b0;
  assign cs_lvl_w[0]  = 1'b1;

  genvar gi;
  generate
    for (gi = 1; gi < 5; gi++) begin : g_cs
      assign cs_func_w[gi] = bus_w & dir_reg[gi];
      assign cs_lvl_w[gi]  = chip_select_n_i[4 - gi];
    end
    for (gi = 0; gi < 5; gi++) begin : g_pad
      wire stby_cs = sw_standby_i & cs_func_w[gi];
      assign drive_next.level[gi] =
        stby_cs          ? drive_reg.level[gi] :
        cs_func_w[gi]    ? cs_lvl_w[gi] :
                           data_reg[gi];
      assign drive_next.oe_n[gi] =
        (stby_cs & ~hold_w) ? 1'b1 :
                              ~dir_reg[gi];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_reg.level <= fbp_pkg::FBP_DATA_RST;
      drive_reg.oe_n  <= 5'h1F;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign wb_dat_o            = dat_reg;
  assign wb_ack_o            = ack_reg;
  assign pin_o               = drive_reg.level;
  assign pin_oe_n_o          = drive_reg.oe_n;
  assign ext_interrupt_6_n_o = int6_reg;
  assign ext_interrupt_7_n_o = int7_reg;
  assign irq_o               = irq_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd_dir;
    rd_w && hit_dir;
  endsequence

  sequence s_rd_pin_live;
    rd_w && hit_pin && !sw_standby_i;
  endsequence

  // three held edges give the strap synchroniser time to fill
  sequence s_init_held;
    rst_i ##1 rst_i ##1 rst_i;
  endsequence

  sequence s_fall6;
    pin_prev_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_6_N] && !pin_s2_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_6_N] && !hws_s2_reg;
  endsequence

  sequence s_fall7;
    pin_prev_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_7_N] && !pin_s2_reg[fbp_pkg::FBP_PIN_EXT_INTERRUPT_7_N] && !hws_s2_reg;
  endsequence

  AST_DIR_INIT: assert property (disable iff (1'b0) s_init_held |=> dir_reg == $past(dir_init_w))
    else $error("direction not set from strap at reset");

  AST_DATA_INIT: assert property (disable iff (1'b0) rst_i |=> data_reg == 5'h00)
    else $error("data register not cleared at reset");

  AST_DIR_NO_READBACK: assert property (s_rd_dir |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("direction register returned stored bits");

  AST_DIR_WRITE: assert property ((wr_w && hit_dir) |=> dir_reg == $past(wb_dat_i[4:0]))
    else $error("direction write lost");

  AST_DIR_KEEP: assert property (!(wr_w && hit_dir) && !hws_s2_reg |=> $stable(dir_reg))
    else $error("direction changed without a write");

  AST_DATA_RESVD: assert property ((rd_w && hit_data) |=> wb_dat_o[31:5] == 27'h0)
    else $error("reserved data bits not filler");

  AST_PIN_RO: assert property ((wr_w && hit_pin && !hws_s2_reg) |=> $stable(data_reg) && $stable(dir_reg))
    else $error("write to pin-state register had an effect");

  AST_PIN_READ: assert property (s_rd_pin_live |=> wb_dat_o[4:0] == $past(pin_view_w))
    else $error("pin-state read mixes data and pad wrongly");

  AST_PIN_HOLD: assert property ((sw_standby_i && !hws_s2_reg) |=> $stable(pin_state_reg))
    else $error("pin snapshot moved in standby");

  AST_CS_HOLD: assert property ((sw_standby_i && hold_w && cs_func_w[4]) |=> pin_o[4] == $past(pin_o[4]))
    else $error("chip select not held in standby");

  AST_CS_FLOAT: assert property ((sw_standby_i && !hold_w && cs_func_w[4]) |=> pin_oe_n_o[4])
    else $error("chip select not released in standby");

  AST_CS_DRIVE: assert property ((!sw_standby_i && cs_func_w[3]) |=> pin_o[3] == $past(chip_select_n_i[1]) && !pin_oe_n_o[3])
    else $error("pin 3 not driving chip select 1");

  AST_PIN0_OUT: assert property ((dir_reg[0] && !hws_s2_reg) |=> pin_o[0] == $past(data_reg[0]) && !pin_oe_n_o[0])
    else $error("pin 0 not driven from data");

  AST_MODE7_PLAIN: assert property ((mode7_w && dir_reg[2] && !hws_s2_reg) |=> pin_o[2] == $past(data_reg[2]))
    else $error("mode 7 pin not driven from data");

  AST_INPUT_FLOAT: assert property ((!dir_reg[1] && !hws_s2_reg) |=> pin_oe_n_o[1])
    else $error("input pin driven");

  AST_INT_ROUTE: assert property (!hws_s2_reg ##1 !hws_s2_reg |-> ext_interrupt_7_n_o == $past(pin_s2_reg[1])
                                  && ext_interrupt_6_n_o == $past(pin_s2_reg[0]))
    else $error("interrupt line does not follow its pad");

  AST_IRQ_LEVEL: assert property (!hws_s2_reg |=> irq_o == |($past(stat_next) & $past(mask_next)))
    else $error("interrupt output does not match status and mask");

  // status bookkeeping: an edge in the read cycle must survive the clear
  AST_STAT_SET6: assert property (s_fall6 |=> stat_reg[fbp_pkg::FBP_STAT_EXT_INTERRUPT_6_N])
    else $error("falling edge on pin 0 not recorded");

  AST_STAT_SET7: assert property (s_fall7 |=> stat_reg[fbp_pkg::FBP_STAT_EXT_INTERRUPT_7_N])
    else $error("falling edge on pin 1 not recorded");

  AST_STAT_READ: assert property ((rd_w && hit_stat) |=> wb_dat_o == {30'h0, $past(stat_reg)})
    else $error("status read did not return the pre-clear value");

  AST_STAT_CLEAR: assert property ((rd_w && hit_stat && fall_w == 2'h0) |=> stat_reg == 2'h0)
    else $error("status not cleared by its read");

  AST_HWS_INIT: assert property (hws_s2_reg |=> data_reg == 5'h00 && dir_reg == $past(dir_init_w))
    else $error("hardware standby did not initialise the port");

  // chip-select routing per pin
  AST_CS_PIN4: assert property ((!sw_standby_i && cs_func_w[4]) |=> pin_o[4] == $past(chip_select_n_i[0]))
    else $error("pin 4 not driving chip select 0");

  AST_CS_PIN1: assert property ((!sw_standby_i && cs_func_w[1]) |=> pin_o[1] == $past(chip_select_n_i[3]))
    else $error("pin 1 not driving chip select 3");

  AST_CS_HOLD_DRIVE: assert property ((sw_standby_i && hold_w && cs_func_w[4]) |=> !pin_oe_n_o[4])
    else $error("held chip select stopped driving in standby");

  AST_CS_FLOAT_ONE: assert property ((sw_standby_i && !hold_w && cs_func_w[1]) |=> pin_oe_n_o[1])
    else $error("pin 1 chip select not released in standby");

  AST_PIN_RESVD: assert property ((rd_w && hit_pin) |=> wb_dat_o[31:5] == 27'h0)
    else $error("reserved pin-state bits not filler");

  AST_MODE_FIXED: assert property (!hws_s2_reg |=> $stable(mode_reg))
    else $error("operating mode changed outside reset");

endmodule // fbp_port

`default_nettype wire

// >>> testbench/fbp_pads.sv
// pad model: the outside devices that share the five port pins
// assumes active-low pad enables from the port and a level chosen by the bench for released pads
`timescale 1ns/1ps
`default_nettype none
module fbp_pads (
  input  wire logic [4:0] pin_o_i,
  input  wire logic [4:0] oe_n_i,
  input  wire logic [4:0] ext_i,
  output logic      [4:0] pin_i_o
);
  // a pad that the port drives shows its level, a released one the outside level
  always_comb begin
    for (int b = 0; b < 5; b++) begin
      pin_i_o[b] = oe_n_i[b] ? ext_i[b] : pin_o_i[b];
    end
  end
endmodule // fbp_pads
`default_nettype wire

// >>> testbench/fbp_port_tb_top.sv
// self-checking bench for the five-bit port: bus tasks, pad model, queue of expected reads
// assumes the port answers each bus request with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module fbp_port_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        sw_sb = 1'b0;
  logic        hw_sb = 1'b0;
  logic [17:0] adr = 18'h00000;
  logic [31:0] dat = 32'h00000000;
  logic [1:0]  mode = 2'h0;
  logic [3:0]  cs_n = 4'hF;
  logic [4:0]  ext = 5'h1F;
  logic [4:0]  pin_in;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [4:0]  pin_o;
  logic [4:0]  pin_oe_n_o;
  logic        int6_n;
  logic        int7_n;
  logic        irq_o;
  logic [7:0]  q[$];
  logic [7:0]  d;
  logic [7:0]  e;
  int          seed = 78613;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #5 clk_i = ~clk_i;

  fbp_port fbp_port_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mode_i(mode), .hw_standby_i(hw_sb), .sw_standby_i(sw_sb), .chip_select_n_i(cs_n), .pin_i(pin_in),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .ext_interrupt_6_n_o(int6_n), .ext_interrupt_7_n_o(int7_n),
    .irq_o(irq_o));
  fbp_pads fbp_pads_inst (.pin_o_i(pin_o), .oe_n_i(pin_oe_n_o), .ext_i(ext), .pin_i_o(pin_in));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until the edge that samples ack, released right after it
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, v};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    q.push_back(exp);
    wb(1'b0, idx, 8'h00);
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clk_i);
    rst_i <= 1'b1;
    mode <= m;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // read data is judged at the ack edge against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && q.size() > 0) chk(wb_dat_o[7:0], q.pop_front());
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0]);
      chk({3'h0, pin_oe_n_o}, (m < 2) ? 8'h0F : 8'h1F);
      rd(fbp_pkg::FBP_IDX_DATA, 8'h00);
      rd(fbp_pkg::FBP_IDX_DIR, fbp_pkg::FBP_UNDEF_READ);
    end
    $display("reset values done");
    d = 8'($random(seed));
    wb(1'b1, fbp_pkg::FBP_IDX_DATA, d | 8'hE0);
    wb(1'b1, fbp_pkg::FBP_IDX_DIR, 8'hFF);
    repeat (2) @(posedge clk_i);
    chk({3'h0, pin_o}, {3'h0, d[4:0]});
    chk({3'h0, pin_oe_n_o}, 8'h00);
    rd(fbp_pkg::FBP_IDX_PIN, {3'h0, d[4:0]});
    wb(1'b1, fbp_pkg::FBP_IDX_PIN, ~d);
    rd(fbp_pkg::FBP_IDX_DATA, {3'h0, d[4:0]});
    ext <= 5'($random(seed));
    wb(1'b1, fbp_pkg::FBP_IDX_DIR, 8'h00);
    repeat (5) @(posedge clk_i);
    rd(fbp_pkg::FBP_IDX_PIN, {3'h0, ext});
    $display("plain port mode done");
    do_reset(2'h0);
    cs_n <= 4'($random(seed));
    wb(1'b1, fbp_pkg::FBP_IDX_DATA, d);
    wb(1'b1, fbp_pkg::FBP_IDX_DIR, 8'h1F);
    repeat (2) @(posedge clk_i);
    chk({3'h0, pin_o}, {3'h0, cs_n[0], cs_n[1], cs_n[2], cs_n[3], d[0]});
    sw_sb <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({3'h0, pin_oe_n_o}, 8'h1E);
    sw_sb <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({3'h0, pin_oe_n_o}, 8'h00);
    e = {3'h0, cs_n[0], cs_n[1], cs_n[2], cs_n[3], d[0]};
    wb(1'b1, fbp_pkg::FBP_IDX_CTRL, 8'h01);
    rd(fbp_pkg::FBP_IDX_CTRL, 8'h01);
    sw_sb <= 1'b1;
    repeat (2) @(posedge clk_i);
    cs_n <= ~cs_n;
    repeat (3) @(posedge clk_i);
    chk({3'h0, pin_o}, e);
    chk({3'h0, pin_oe_n_o}, 8'h00);
    sw_sb <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({3'h0, pin_o}, e ^ 8'h1E);
    $display("chip select mode done");
    ext <= 5'h1F;
    wb(1'b1, fbp_pkg::FBP_IDX_DIR, 8'h00);
    wb(1'b1, fbp_pkg::FBP_IDX_IRQ_MASK, 8'h01);
    rd(fbp_pkg::FBP_IDX_IRQ_MASK, 8'h01);
    repeat (5) @(posedge clk_i);
    wb(1'b0, fbp_pkg::FBP_IDX_IRQ_STAT, 8'h00);
    ext[1] <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h00);
    chk({6'h00, int7_n, int6_n}, 8'h01);
    rd(fbp_pkg::FBP_IDX_IRQ_STAT, 8'h02);
    ext[0] <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h01);
    chk({6'h00, int7_n, int6_n}, 8'h00);
    rd(fbp_pkg::FBP_IDX_IRQ_STAT, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h00);
    $display("interrupt pins done");
    hw_sb <= 1'b1;
    repeat (4) @(posedge clk_i);
    hw_sb <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({3'h0, pin_oe_n_o}, 8'h0F);
    rd(fbp_pkg::FBP_IDX_DATA, 8'h00);
    rd(fbp_pkg::FBP_IDX_IRQ_STAT, 8'h00);
    rd(fbp_pkg::FBP_IDX_CTRL, 8'h00);
    $display("hardware standby done");
    end_of_test();
  end
endmodule // fbp_port_tb_top
`default_nettype wire
